//--- sipo_shifter.sv
// Eight-stage serial-in parallel-out shifter with AND-gated input and inverted outputs
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Eight stages chained, fed from two serial data inputs.
// - Serial bit is the AND of both data inputs.
// - Apart from clear, only a rising edge of the shift clock changes the stages.
// - On a rising edge, first stage takes serial bit, others take predecessor.
// - Value in the eighth stage is dropped on every shift.
// - Clear low forces every stage to zero regardless of clock and data.
// - While clear is low, all outputs are high and edges do nothing.
// - Each output is the inverse of its stage bit.
module sipo_shifter (
  // System clock and reset
  input  wire logic              clock,
  input  wire logic              resetn,
  // Controller pins
  input  wire sipo_pkg::sipo_pins_s pins,
  // Parallel outputs, inverted
  output logic [7:0]             parallel_output_n,
  output logic                   first_stage_output_n,
  output logic                   final_stage_output_n
);


  // Width of the pin bundle, so the synchroniser tracks the struct
  localparam int unsigned PIN_COUNT  = $bits(sipo_pkg::sipo_pins_s);
  localparam int unsigned LAST_SYNC  = sipo_pkg::SYNC_DEPTH - 1;
  localparam int unsigned LAST_STAGE = sipo_pkg::STAGE_COUNT - 1;

  // What the stage chain does at the next system edge
  typedef enum {
    SIPO_HOLD,
    SIPO_SHIFT,
    SIPO_CLEAR
  } sipo_action_e;

  // Next value of one stage for a given action
  function automatic logic sipo_stage_next(
    input sipo_action_e act,
    input logic         hold,
    input logic         feed,
    input logic         cleared
  );
    logic result;
    result = hold;
    case (act)
      SIPO_CLEAR: begin
        result = cleared;
      end
      SIPO_SHIFT: begin
        result = feed;
      end
      SIPO_HOLD: begin
        result = hold;
      end
      default: begin
        result = hold;
      end
    endcase
    return result;
  endfunction : sipo_stage_next

  // Rising edge between two successive synchronised samples
  function automatic logic sipo_rise(
    input logic now,
    input logic prev
  );
    return now & ~prev;
  endfunction : sipo_rise

  // Synchroniser chain, one entry per flop stage
  logic [PIN_COUNT-1:0]              pin_vector;
  logic [PIN_COUNT-1:0]              sync_chain [sipo_pkg::SYNC_DEPTH];
  sipo_pkg::sipo_pins_s              sync_pins;

  // Edge detection and decoded controls
  logic                              clock_prev;
  logic                              shift_edge;
  logic                              clear_active;
  logic                              serial_bit;
  sipo_action_e                      action;

  // Stage storage
  logic [sipo_pkg::STAGE_COUNT-1:0]  stages;
  wire logic [sipo_pkg::STAGE_COUNT-1:0] stage_input;
  wire logic [sipo_pkg::STAGE_COUNT-1:0] next_stages;

  assign pin_vector = pins;

  // Pins are asynchronous to the system clock; all fields share one delay so
  // data stays aligned with the clock edge it was set up for. Unequal delays
  // per field would let data skew past its own clock edge.
  always_ff @(posedge clock) begin
    if (!resetn) begin
      for (int d = 0; d < sipo_pkg::SYNC_DEPTH; d++) begin
        sync_chain[d] <= sipo_pkg::PINS_RESET;
      end
    end else begin
      sync_chain[0] <= pin_vector;
      for (int d = 1; d < sipo_pkg::SYNC_DEPTH; d++) begin
        sync_chain[d] <= sync_chain[d-1];
      end
    end
  end

  assign sync_pins = sipo_pkg::sipo_pins_s'(sync_chain[LAST_SYNC]);

  // Previous synchronised shift clock level for edge detection
  always_ff @(posedge clock) begin
    if (!resetn) begin
      clock_prev <= 1'b0;
    end else begin
      clock_prev <= sync_pins.shift_clock;
    end
  end

  assign shift_edge   = sipo_rise(sync_pins.shift_clock, clock_prev);
  assign serial_bit   = sync_pins.serial_a & sync_pins.serial_b;
  assign clear_active = ~sync_pins.async_zeroing_input_n;

  // Clear outranks a shift edge landing in the same cycle
  always_comb begin
    action = SIPO_HOLD;
    if (clear_active) begin
      action = SIPO_CLEAR;
    end else if (shift_edge) begin
      action = SIPO_SHIFT;
    end else begin
      action = SIPO_HOLD;
    end
  end

  // Chain wiring: stage zero takes the serial bit, every other stage its
  // predecessor. The last stage feeds nothing, so its bit is lost on a shift.
  generate
    for (genvar s = 0; s < sipo_pkg::STAGE_COUNT; s++) begin : g_stage
      if (s == 0) begin : g_head
        assign stage_input[s] = serial_bit;
      end else begin : g_link
        assign stage_input[s] = stages[s-1];
      end
      assign next_stages[s] = sipo_stage_next(action,
                                              stages[s],
                                              stage_input[s],
                                              sipo_pkg::STAGE_RESET[s]);
    end
  endgenerate

  // Clear reaches the stages three system cycles after the pin falls; it cannot be truly
  // immediate without reading an unsynchronised pin
  always_ff @(posedge clock) begin
    if (!resetn) begin
      stages <= sipo_pkg::STAGE_RESET;
    end else begin
      stages <= next_stages;
    end
  end

  // Outputs are inverted stage bits, so a cleared chain reads all high
  assign parallel_output_n    = ~stages;
  assign first_stage_output_n = parallel_output_n[0];
  assign final_stage_output_n = parallel_output_n[LAST_STAGE];

endmodule : sipo_shifter
`default_nettype wire

//--- sipo_pkg.sv
// Package: constants and pin bundle for the serial-in parallel-out shifter
`default_nettype none
package sipo_pkg;
  localparam int unsigned STAGE_COUNT = 8;
  localparam logic [7:0]  STAGE_RESET = 8'h00;
  localparam int unsigned SYNC_DEPTH  = 2;

  // Pin levels from the controller, sampled together
  typedef struct packed {
    logic shift_clock;
    logic serial_a;
    logic serial_b;
    logic async_zeroing_input_n;
  } sipo_pins_s;

  localparam sipo_pins_s PINS_RESET = '{
    shift_clock:           1'b0,
    serial_a:              1'b0,
    serial_b:              1'b0,
    async_zeroing_input_n: 1'b0
  };
endpackage : sipo_pkg
`default_nettype wire

//--- sipo_shifter_asserts.sv
// Port checker for the shifter
`timescale 1ns/1ps
`default_nettype none
module sipo_shifter_chk (input wire logic clock, resetn, input wire sipo_pkg::sipo_pins_s pins,
  input wire logic [7:0] parallel_output_n, input wire logic first_stage_output_n,
  final_stage_output_n);
  wire [3:0] p = pins;
  wire [7:0] q = parallel_output_n;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  property p_clr; !$past(p[0], 3) |-> q == 8'hFF; endproperty
  a_clr: assert property (p_clr) else $error("clear");
  property p_sh; $past(p[0] && p[3], 3) && !$past(p[3], 4)
    |-> q[0] == !$past(p[1] && p[2], 3) && q[7:1] == $past(q[6:0]); endproperty
  a_sh: assert property (p_sh) else $error("shift");
  property p_hold; !($past(p[3], 3) && !$past(p[3], 4)) && $past(p[0], 3) |-> $stable(q); endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_tap; first_stage_output_n == q[0] && final_stage_output_n == q[7]; endproperty
  a_tap: assert property (p_tap) else $error("taps");
  property p_drop; $past(p[0] && p[3], 3) && !$past(p[3], 4) |-> q[7] == $past(q[6]); endproperty
  a_drop: assert property (p_drop) else $error("drop");
  property p_and; $past(p[0] && p[3] && !(p[2] && p[1]), 3) && !$past(p[3], 4) |-> q[0];
  endproperty
  a_and: assert property (p_and) else $error("and gate");
  c_one: cover property ($past(p[0] && p[3] && p[2] && p[1], 3) && !$past(p[3], 4));
  c_clr: cover property (!$past(p[0], 3) && $past(q) != 8'hFF);
  c_last: cover property (q[7] == 1'b0);
endmodule : sipo_shifter_chk
bind sipo_shifter sipo_shifter_chk chk (.*);
`default_nettype wire

//--- sipo_ctrl.sv
// Controller pin model; every level stands three cycles
`timescale 1ns/1ps
`default_nettype none
module sipo_ctrl (input wire logic clock, output var sipo_pkg::sipo_pins_s pins);
  initial pins = sipo_pkg::PINS_RESET;
  task automatic drive(input logic c, a, b, z);
    @(posedge clock) pins <= '{c, a, b, z};
    repeat (2) @(posedge clock);
  endtask : drive
endmodule : sipo_ctrl
`default_nettype wire

//--- tb_sipo_shifter.sv
// Self-checking bench for the shifter
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
  $display("CHECK FAILED %0t %h %h", $time, a, b); end end
module tb_sipo_shifter;
  logic clock = 0, resetn = 0, f0, f7;
  logic [7:0] q, e = 8'h00;
  int error_cnt = 0, n_compared = 0;
  sipo_pkg::sipo_pins_s pins;
  always #5 clock = ~clock;
  sipo_ctrl ctl (.clock(clock), .pins(pins));
  sipo_shifter dut (.clock(clock), .resetn(resetn), .pins(pins), .parallel_output_n(q),
    .first_stage_output_n(f0), .final_stage_output_n(f7));
  task automatic shift(input logic a, b);
    ctl.drive(1'b0, a, b, 1'b1);
    ctl.drive(1'b1, a, b, 1'b1);
    ctl.drive(1'b1, ~a, ~b, 1'b1); // Data moves while clock high
    e = {e[6:0], a & b};
    `CHK(q, ~e)
    `CHK({f0, f7}, {~e[0], ~e[7]})
  endtask : shift
  task automatic print_verdict;
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    ctl.drive(1'b0, 1'b0, 1'b0, 1'b1);
    `CHK(q, 8'hFF)
    for (int i = 0; i < 10; i++) shift(i[0], i != 5);
    ctl.drive(1'b0, 1'b1, 1'b1, 1'b1);
    ctl.drive(1'b1, 1'b1, 1'b1, 1'b0);
    ctl.drive(1'b1, 1'b1, 1'b1, 1'b0);
    `CHK(q, 8'hFF)
    print_verdict;
  end
endmodule : tb_sipo_shifter
`default_nettype wire
